//--- src/peak_if.sv
// Purpose: Carries phase magnitudes to a peak tracker and back.
// Assumes: Three phases, 24-bit magnitudes.
// Notes: One instance per channel.
`timescale 1ns/1ps
`default_nettype none
interface peak_if;
  logic valid; // Sample strobe.
  logic [2:0][23:0] mag; // Absolute value per phase.
  logic [2:0] sel; // Phases taking part.
  logic win_end; // Window boundary pulse.
  logic [23:0] peak; // Published peak.
  logic [2:0] tag; // One-hot phase of the published peak.
  modport src (output valid, mag, sel, win_end, input peak, tag);
  modport trk (input valid, mag, sel, win_end, output peak, tag);
endinterface
`default_nettype wire

//--- src/peak_overlevel_top.sv
// Purpose: Peak capture and over-level detection on three phases.
// Assumes: Samples and zero-crossing pulses are synchronous.
// Notes: Registers are reached through a simple register port.
//
// Overview of operation
// - Hold peak magnitudes in low 24 bits.
// - Window counts half cycles from zero crossings.
// - Mode bits 4:2 enable phases A, B, C.
// - All selected phases advance the window count.
// - Bits 26:24 hold one-hot peak phase.
// - Peak published at window end, then held.
// - Current window end sets status bit 23.
// - Voltage window end sets status bit 24.
// - Write one clears peak flags; zero keeps.
// - Window length write restarts the counter if a phase is selected.
// - Magnitude strictly above limit flags event.
// - Voltage excess sets bit 18, phase bits.
// - Clearing bit 18 clears bits 11:9.
// - Current excess sets bit 17, phase bits.
// - Clearing bit 17 clears bits 5:3.
// - Limit at full scale never detects.
// - Limit of zero detects on every valid sample.
// - Limits read back zero-padded to 32 bits.
`timescale 1ns/1ps
`default_nettype none
module peak_overlevel_top (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic rst_b,
  // Register port.
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  output logic [31:0] reg_rdata,
  // Sample stream and zero crossings.
  input wire logic smp_valid,
  input wire logic [2:0][23:0] cur_smp,
  input wire logic [2:0][23:0] vol_smp,
  input wire logic [2:0] zx_pulse,
  // Interrupt.
  output logic interrupt_out_n
);
  // ************************************************************
  // Reset release.
  // ************************************************************
  logic rst_meta_b_r; // First stage of the release.
  logic rst_sync_b; // Released reset used everywhere else.

  // Assert at once, release after two clock edges.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta_b_r <= 1'b0;
      rst_sync_b <= 1'b0;
    end else begin
      rst_meta_b_r <= 1'b1;
      rst_sync_b <= rst_meta_b_r;
    end
  end

  // ************************************************************
  // Register write decode.
  // ************************************************************
  logic [23:0] cur_lim_r; // Current limit level.
  logic [23:0] vol_lim_r; // Voltage limit level.
  logic [7:0] mode_r; // Measure mode configuration.
  logic [7:0] win_len_r; // Peak window length in half cycles.
  logic [3:0] en_r; // Enables for bits 17, 18, 23, 24.
  logic [2:0] phase_select_field; // Phases in peak measurement.
  logic win_wr; // Write to the window length.
  logic flag_wr; // Write to the event flags.

  assign win_wr = reg_wr && reg_addr == peak_pkg::WIN_LEN_OFS;
  assign flag_wr = reg_wr && reg_addr == peak_pkg::EVT_FLAGS_OFS;
  // Bits 4:2 of the mode choose phases A, B and C.
  assign phase_select_field = mode_r[peak_pkg::SEL_LSB +: 3];

  // Store the writable configuration registers.
  always_ff @(posedge core_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      cur_lim_r <= peak_pkg::LIM_RST;
      vol_lim_r <= peak_pkg::LIM_RST;
      mode_r <= peak_pkg::MODE_RST;
      win_len_r <= peak_pkg::WIN_RST;
      en_r <= peak_pkg::EN_RST;
    end else if (reg_wr) begin
      case (reg_addr)
        peak_pkg::CUR_LIM_OFS: cur_lim_r <= reg_wdata[23:0];
        peak_pkg::VOL_LIM_OFS: vol_lim_r <= reg_wdata[23:0];
        peak_pkg::MODE_OFS: mode_r <= reg_wdata[7:0];
        peak_pkg::WIN_LEN_OFS: win_len_r <= reg_wdata[7:0];
        peak_pkg::EVT_EN_OFS: begin
          en_r <= {reg_wdata[peak_pkg::VWIN_BIT],
                   reg_wdata[peak_pkg::CWIN_BIT],
                   reg_wdata[peak_pkg::HV_BIT],
                   reg_wdata[peak_pkg::HC_BIT]};
        end
        // Other offsets store nothing.
        default: ;
      endcase
    end
  end

  // ************************************************************
  // Per-phase magnitude and limit compare.
  // ************************************************************
  logic [2:0][23:0] cur_mag; // Current magnitudes.
  logic [2:0][23:0] vol_mag; // Voltage magnitudes.
  logic [2:0] hc_hit; // Current excess per phase.
  logic [2:0] hv_hit; // Voltage excess per phase.

  for (genvar g = 0; g < 3; g++) begin : g_ph
    // Two's complement magnitude of the signed sample.
    assign cur_mag[g] = cur_smp[g][23] ? -cur_smp[g] : cur_smp[g];
    assign vol_mag[g] = vol_smp[g][23] ? -vol_smp[g] : vol_smp[g];
    // Zero limit fires on every valid sample; full scale never fires.
    assign hc_hit[g] = smp_valid && (cur_lim_r == '0 ||
      (cur_lim_r < peak_pkg::FULL_SCALE &&
       cur_mag[g] > cur_lim_r));
    assign hv_hit[g] = smp_valid && (vol_lim_r == '0 ||
      (vol_lim_r < peak_pkg::FULL_SCALE &&
       vol_mag[g] > vol_lim_r));
  end

  // ************************************************************
  // Half-cycle counter and window boundary.
  // ************************************************************
  logic [8:0] zc_cnt_r; // Half cycles seen in this window.
  logic [1:0] zx_add; // Selected crossings this cycle.
  logic [8:0] cnt_sum; // Count including this cycle.
  logic win_end; // One-cycle window boundary.
  logic [2:0] zx_sel; // Crossings of selected phases.

  assign zx_sel = zx_pulse & phase_select_field;
  assign zx_add = 2'(zx_sel[0]) + 2'(zx_sel[1]) + 2'(zx_sel[2]);
  assign cnt_sum = zc_cnt_r + 9'(zx_add);
  // A zero length keeps the window open forever.
  assign win_end = win_len_r != '0 &&
                   cnt_sum >= {1'b0, win_len_r};

  // The counter always runs; a length write restarts it when a phase is selected.
  always_ff @(posedge core_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      zc_cnt_r <= '0;
    end else if (win_wr && phase_select_field != '0) begin
      zc_cnt_r <= '0;
    end else if (win_end) begin
      zc_cnt_r <= '0;
    end else begin
      zc_cnt_r <= cnt_sum;
    end
  end

  // ************************************************************
  // Peak trackers.
  // ************************************************************
  peak_if cur_pk ();
  peak_if vol_pk ();

  assign cur_pk.valid = smp_valid;
  assign cur_pk.mag = cur_mag;
  assign cur_pk.sel = phase_select_field;
  assign cur_pk.win_end = win_end;
  assign vol_pk.valid = smp_valid;
  assign vol_pk.mag = vol_mag;
  assign vol_pk.sel = phase_select_field;
  assign vol_pk.win_end = win_end;

  // Current channel maximum.
  peak_tracker u_cur (
    .core_clk (core_clk),
    .rst_sync_b (rst_sync_b),
    .pk (cur_pk.trk)
  );

  // Voltage channel maximum.
  peak_tracker u_vol (
    .core_clk (core_clk),
    .rst_sync_b (rst_sync_b),
    .pk (vol_pk.trk)
  );

  // ************************************************************
  // Event flags.
  // ************************************************************
  logic current_window_done_flag; // Status bit 23.
  logic voltage_window_done_flag; // Status bit 24.
  logic high_current_flag; // Status bit 17.
  logic high_voltage_flag; // Status bit 18.
  logic [2:0] high_current_phase_bits; // Phase bits 5:3.
  logic [2:0] high_voltage_phase_bits; // Phase bits 11:9.
  logic clr_cwin; // Clear request for bit 23.
  logic clr_vwin; // Clear request for bit 24.
  logic clr_hc; // Clear request for bit 17.
  logic clr_hv; // Clear request for bit 18.

  assign clr_cwin = flag_wr && reg_wdata[peak_pkg::CWIN_BIT];
  assign clr_vwin = flag_wr && reg_wdata[peak_pkg::VWIN_BIT];
  assign clr_hc = flag_wr && reg_wdata[peak_pkg::HC_BIT];
  assign clr_hv = flag_wr && reg_wdata[peak_pkg::HV_BIT];

  // Window flags; a new boundary wins over a clear.
  always_ff @(posedge core_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      current_window_done_flag <= 1'b0;
      voltage_window_done_flag <= 1'b0;
    end else begin
      current_window_done_flag <= win_end ||
        (current_window_done_flag && !clr_cwin);
      voltage_window_done_flag <= win_end ||
        (voltage_window_done_flag && !clr_vwin);
    end
  end

  // Excess flags and phase bits clear together.
  always_ff @(posedge core_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      high_current_flag <= 1'b0;
      high_voltage_flag <= 1'b0;
      high_current_phase_bits <= '0;
      high_voltage_phase_bits <= '0;
    end else begin
      high_current_flag <= (|hc_hit) ||
        (high_current_flag && !clr_hc);
      high_current_phase_bits <= hc_hit |
        (high_current_phase_bits & {3{!clr_hc}});
      high_voltage_flag <= (|hv_hit) ||
        (high_voltage_flag && !clr_hv);
      high_voltage_phase_bits <= hv_hit |
        (high_voltage_phase_bits & {3{!clr_hv}});
    end
  end

  // ************************************************************
  // Status words, read port and interrupt.
  // ************************************************************
  logic [31:0] st_word; // Event flags as read.
  logic [31:0] en_word; // Enables as read.
  logic [15:0] ph_word; // Phase flags as read.

  // Place flags and enables at their bit positions.
  always_comb begin
    st_word = '0;
    en_word = '0;
    ph_word = '0;
    st_word[peak_pkg::HC_BIT] = high_current_flag;
    st_word[peak_pkg::HV_BIT] = high_voltage_flag;
    st_word[peak_pkg::CWIN_BIT] = current_window_done_flag;
    st_word[peak_pkg::VWIN_BIT] = voltage_window_done_flag;
    en_word[peak_pkg::HC_BIT] = en_r[0];
    en_word[peak_pkg::HV_BIT] = en_r[1];
    en_word[peak_pkg::CWIN_BIT] = en_r[2];
    en_word[peak_pkg::VWIN_BIT] = en_r[3];
    ph_word[peak_pkg::HC_PH_LSB +: 3] = high_current_phase_bits;
    ph_word[peak_pkg::HV_PH_LSB +: 3] = high_voltage_phase_bits;
  end

  // Registered read data; unmapped offsets read zero.
  always_ff @(posedge core_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      case (reg_addr)
        peak_pkg::PEAK_CUR_OFS:
          reg_rdata <= {5'h0, cur_pk.tag, cur_pk.peak};
        peak_pkg::PEAK_VOL_OFS:
          reg_rdata <= {5'h0, vol_pk.tag, vol_pk.peak};
        peak_pkg::CUR_LIM_OFS:
          reg_rdata <= {8'h00, cur_lim_r};
        peak_pkg::VOL_LIM_OFS:
          reg_rdata <= {8'h00, vol_lim_r};
        peak_pkg::PHASE_FLAGS_OFS: reg_rdata <= {16'h0000, ph_word};
        peak_pkg::MODE_OFS: reg_rdata <= {24'h00_0000, mode_r};
        peak_pkg::WIN_LEN_OFS: reg_rdata <= {24'h00_0000, win_len_r};
        peak_pkg::EVT_FLAGS_OFS: reg_rdata <= st_word;
        peak_pkg::EVT_EN_OFS: reg_rdata <= en_word;
        default: reg_rdata <= '0;
      endcase
    end
  end

  // Interrupt is low while any enabled flag stands.
  always_ff @(posedge core_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      interrupt_out_n <= 1'b1;
    end else begin
      interrupt_out_n <= ~|(st_word & en_word);
    end
  end

  // ************************************************************
  // Checks.
  // ************************************************************
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_sync_b);

  irq_follow_a: assert property (
    ##1 interrupt_out_n == !(|($past(st_word) & $past(en_word))))
    else $error("Interrupt does not follow enabled flags.");
  cwin_set_a: assert property (
    win_end |=> current_window_done_flag ##1 (current_window_done_flag
      || $past(clr_cwin)))
    else $error("Current window flag not set.");
  vwin_set_a: assert property (
    win_end |=> voltage_window_done_flag)
    else $error("Voltage window flag not set.");
  pk_clear_a: assert property (
    clr_cwin && !win_end |=> !current_window_done_flag)
    else $error("Current window flag not cleared.");
  pk_keep_a: assert property (
    flag_wr && !clr_vwin && voltage_window_done_flag
      |=> voltage_window_done_flag)
    else $error("Voltage window flag lost on zero write.");
  peak_hold_a: assert property (
    !win_end |=> $stable(cur_pk.peak) && $stable(cur_pk.tag))
    else $error("Peak changed inside a window.");
  tag_onehot_a: assert property (
    $onehot0(vol_pk.tag) && $onehot0(cur_pk.tag))
    else $error("Peak phase tag is not one-hot.");
  hv_set_a: assert property (
    hv_hit[0] |=> high_voltage_flag && high_voltage_phase_bits[0])
    else $error("Voltage excess not flagged.");
  hv_clear_a: assert property (
    clr_hv && hv_hit == '0 |=> !high_voltage_flag
      && high_voltage_phase_bits == '0)
    else $error("Voltage excess not cleared.");
  hc_clear_a: assert property (
    clr_hc && hc_hit == '0 |=> !high_current_flag
      && high_current_phase_bits == '0)
    else $error("Current excess not cleared.");
  full_scale_a: assert property (
    cur_lim_r == peak_pkg::FULL_SCALE |-> hc_hit == '0)
    else $error("Excess seen at full-scale limit.");
  zero_lim_a: assert property (
    vol_lim_r == '0 && smp_valid |=> high_voltage_flag)
    else $error("Zero limit did not flag excess.");
  cnt_restart_a: assert property (
    win_wr && phase_select_field != '0 |=> zc_cnt_r == '0)
    else $error("Length write did not restart count.");
endmodule // peak_overlevel_top
`default_nettype wire

//--- src/peak_pkg.sv
// Purpose: Shared constants of the peak and over-level detector.
// Assumes: One 100 MHz core clock; 24-bit signed phase samples.
// Notes: Offsets are register indexes on the register port.
package peak_pkg;
  // ************************************************************
  // Register offsets.
  // ************************************************************
  localparam logic [15:0] PEAK_CUR_OFS = 16'he500;
  localparam logic [15:0] PEAK_VOL_OFS = 16'he501;
  localparam logic [15:0] CUR_LIM_OFS = 16'he507;
  localparam logic [15:0] VOL_LIM_OFS = 16'he508;
  localparam logic [15:0] PHASE_FLAGS_OFS = 16'he600;
  localparam logic [15:0] MODE_OFS = 16'he700;
  localparam logic [15:0] WIN_LEN_OFS = 16'he703;
  localparam logic [15:0] EVT_FLAGS_OFS = 16'hea01;
  localparam logic [15:0] EVT_EN_OFS = 16'hea02;
  // ************************************************************
  // Field positions.
  // ************************************************************
  localparam int HC_BIT = 17;
  localparam int HV_BIT = 18;
  localparam int CWIN_BIT = 23;
  localparam int VWIN_BIT = 24;
  localparam int SEL_LSB = 2;
  localparam int TAG_LSB = 24;
  localparam int HC_PH_LSB = 3;
  localparam int HV_PH_LSB = 9;
  // ************************************************************
  // Values after reset and fixed levels.
  // ************************************************************
  localparam logic [23:0] FULL_SCALE = 24'h51_2D40;
  localparam logic [23:0] LIM_RST = 24'h51_2D40;
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [7:0] WIN_RST = 8'h00;
  localparam logic [3:0] EN_RST = 4'h0;
endpackage

//--- src/peak_tracker.sv
// Purpose: Running maximum over one window for one channel.
// Assumes: Reset is already synchronised.
// Notes: Result is published on the window boundary pulse.
`timescale 1ns/1ps
`default_nettype none
module peak_tracker (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic rst_sync_b,
  // Channel link.
  peak_if.trk pk
);
  logic [23:0] run_r; // Running maximum of this window.
  logic [2:0] run_tag_r; // Phase of the running maximum.
  logic [23:0] best; // Maximum including this cycle.
  logic [2:0] best_tag; // Phase of that maximum.

  // Fold the selected phases of this sample into the maximum.
  always_comb begin
    best = run_r;
    best_tag = run_tag_r;
    for (int i = 0; i < 3; i++) begin
      if (pk.valid && pk.sel[i] && pk.mag[i] > best) begin
        best = pk.mag[i];
        // A whole one-hot word drops the older phase bit.
        best_tag = '0;
        best_tag[i] = 1'b1;
      end
    end
  end

  // Publish at the boundary and restart the running maximum.
  always_ff @(posedge core_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      run_r <= '0;
      run_tag_r <= '0;
      pk.peak <= '0;
      pk.tag <= '0;
    end else if (pk.win_end) begin
      pk.peak <= best;
      pk.tag <= best_tag;
      run_r <= '0;
      run_tag_r <= '0;
    end else begin
      run_r <= best;
      run_tag_r <= best_tag;
    end
  end
endmodule // peak_tracker
`default_nettype wire

//--- tb/testbench.sv
// Purpose: Self-checking bench for the peak and over-level detector.
// Assumes: Register strobes are one-cycle pulses; samples are pulsed.
// Notes: Random stimulus from a fixed seed, with corner cases mixed in.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  // ******************************************************************
  // Signals and counters.
  // ******************************************************************
  logic core_clk; // Core clock, 100 MHz.
  logic rst_b; // Reset, active low.
  logic reg_wr; // Register write strobe.
  logic reg_rd; // Register read strobe.
  logic [15:0] reg_addr; // Register offset.
  logic [31:0] reg_wdata; // Write data.
  logic [31:0] reg_rdata; // Read data.
  logic smp_valid; // Sample strobe.
  logic [2:0][23:0] cur_smp; // Current samples.
  logic [2:0][23:0] vol_smp; // Voltage samples.
  logic [2:0] zx_pulse; // Zero-crossing pulses.
  logic interrupt_out_n; // Interrupt, active low.
  int error_cnt = 0; // Mismatches seen.
  int total_checks = 0; // Comparisons made.
  int cycles = 0; // Clock cycles run.
  logic [31:0] d; // Last word read.
  logic [23:0] pk_exp [2]; // Peaks published by the last window.
  logic [2:0] tag_exp [2]; // Tags published by the last window.
  bit prev_ok = 0; // The last window's peaks are known.

  peak_overlevel_top peak_overlevel_top_i (.core_clk(core_clk),
    .rst_b(rst_b), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .smp_valid(smp_valid),
    .cur_smp(cur_smp), .vol_smp(vol_smp), .zx_pulse(zx_pulse),
    .interrupt_out_n(interrupt_out_n));

  // The clock toggles every half period.
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // A hang is cut short well past the expected run length.
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      error_cnt++;
      $display("ERROR %0t: run did not finish in time", $time);
      wrap_up();
    end
  end

  // ******************************************************************
  // Bus cycles, stimulus and comparison tasks.
  // ******************************************************************
  // Waits n edges, then steps just past the last one.
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  // One write; an idle cycle follows so strobes never merge.
  task automatic wr(input logic [15:0] a, input logic [31:0] v);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = v;
    tick(1);
    reg_wr = 1'b0;
    tick(1);
  endtask

  // One read; the word lands on the edge that takes the strobe.
  task automatic rd(input logic [15:0] a);
    reg_rd = 1'b1;
    reg_addr = a;
    tick(1);
    reg_rd = 1'b0;
    d = reg_rdata;
    tick(1);
  endtask

  // Counts one comparison and reports a mismatch.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string what);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  // Reads a register and compares it.
  task automatic rchk(input logic [15:0] a, input logic [31:0] exp,
                      input string what);
    rd(a);
    chk(d, exp, what);
  endtask

  // One sample strobe for both channels.
  task automatic sample(input logic [2:0][23:0] c,
                        input logic [2:0][23:0] v);
    smp_valid = 1'b1;
    cur_smp = c;
    vol_smp = v;
    tick(1);
    smp_valid = 1'b0;
    tick(1);
  endtask

  // One zero-crossing pulse; returns after the interrupt has settled.
  task automatic zx(input logic [2:0] z);
    zx_pulse = z;
    tick(1);
    zx_pulse = 3'b000;
    tick(1);
  endtask

  // Magnitude of a signed 24-bit sample.
  function automatic logic [23:0] mag(input logic [23:0] v);
    return v[23] ? 24'(-v) : v;
  endfunction

  // A sample of the given magnitude with a random sign.
  function automatic logic [23:0] rnd_smp(input logic [23:0] m);
    return ($urandom_range(1, 0) == 1) ? 24'(-m) : m;
  endfunction

  // ******************************************************************
  // Scenarios.
  // ******************************************************************
  // Over-level on one channel: 0 is current, 1 is voltage.
  task automatic excess(input int c);
    logic [15:0] la;
    int fb;
    int pl;
    int ph;
    logic [23:0] m;
    logic [2:0][23:0] z;
    la = c ? peak_pkg::VOL_LIM_OFS : peak_pkg::CUR_LIM_OFS;
    fb = c ? peak_pkg::HV_BIT : peak_pkg::HC_BIT;
    pl = c ? peak_pkg::HV_PH_LSB : peak_pkg::HC_PH_LSB;
    ph = $urandom_range(2, 0);
    m = 24'($urandom_range(24'h40_0000, 24'h10));
    z = '0;
    wr(peak_pkg::EVT_EN_OFS, 32'h1 << fb);
    wr(la, {8'hff, m});
    rchk(la, {8'h00, m}, "limit readback");
    z[ph] = rnd_smp(m);
    if (c == 1) sample('0, z);
    else sample(z, '0);
    rchk(peak_pkg::EVT_FLAGS_OFS, 32'h0, "equal level");
    z[ph] = rnd_smp(m + 24'h1);
    if (c == 1) sample('0, z);
    else sample(z, '0);
    tick(1);
    chk({31'h0, interrupt_out_n}, 32'h0, "excess irq");
    rchk(peak_pkg::EVT_FLAGS_OFS, 32'h1 << fb, "excess");
    rchk(peak_pkg::PHASE_FLAGS_OFS, 32'h1 << (pl + ph),
         "phase");
    wr(peak_pkg::EVT_FLAGS_OFS, 32'h0);
    rchk(peak_pkg::EVT_FLAGS_OFS, 32'h1 << fb, "zero keeps");
    wr(peak_pkg::EVT_FLAGS_OFS, 32'h1 << fb);
    tick(1);
    chk({31'h0, interrupt_out_n}, 32'h1, "irq release");
    rchk(peak_pkg::EVT_FLAGS_OFS, 32'h0, "cleared");
    rchk(peak_pkg::PHASE_FLAGS_OFS, 32'h0, "phase clr");
    wr(la, 32'h0);
    sample('0, '0);
    rchk(peak_pkg::EVT_FLAGS_OFS, 32'h1 << fb, "zero limit");
    wr(la, {8'h00, peak_pkg::FULL_SCALE});
    wr(peak_pkg::EVT_FLAGS_OFS, 32'h1 << fb);
    // A sample beyond full scale must still be ignored at that limit.
    z[ph] = rnd_smp(peak_pkg::FULL_SCALE + 24'h1);
    sample(z, z);
    rchk(peak_pkg::EVT_FLAGS_OFS, 32'h0, "full scale");
    wr(peak_pkg::EVT_EN_OFS, 32'h0);
    $display("test excess %0d done", c);
  endtask

  // One window of len selected crossings with random samples.
  task automatic run_win(input logic [2:0] sel, input int len,
                         input bit chk_on);
    logic [23:0] pk [2];
    logic [2:0] tg [2];
    logic [2:0][23:0] s [2];
    int k;
    int p;
    int ch;
    pk[0] = '0;
    pk[1] = '0;
    tg[0] = '0;
    tg[1] = '0;
    for (k = 0; k < len; k++) begin
      // Unselected phases carry large values that must be ignored.
      for (ch = 0; ch < 2; ch++) begin
        for (p = 0; p < 3; p++) begin
          s[ch][p] = sel[p] ? rnd_smp(24'($urandom_range(24'h50_0000, 1)))
                            : rnd_smp(peak_pkg::FULL_SCALE - 24'h1);
          if (sel[p] && mag(s[ch][p]) > pk[ch]) begin
            pk[ch] = mag(s[ch][p]);
            tg[ch] = 3'b001 << p;
          end
        end
      end
      sample(s[0], s[1]);
      if (sel != 3'b111) zx(~sel);
      if (chk_on && prev_ok && k == len - 1) begin
        rchk(peak_pkg::EVT_FLAGS_OFS, 32'h0, "early end");
        rchk(peak_pkg::PEAK_CUR_OFS, {5'h0, tag_exp[0], pk_exp[0]},
             "held");
      end
      do p = $urandom_range(2, 0);
      while (sel[p] == 1'b0);
      zx(3'b001 << p);
    end
    if (chk_on) begin
      chk({31'h0, interrupt_out_n}, 32'h0, "window irq");
      rchk(peak_pkg::EVT_FLAGS_OFS, 32'h0180_0000, "done");
      rchk(peak_pkg::PEAK_CUR_OFS, {5'h0, tg[0], pk[0]},
           "cur peak");
      rchk(peak_pkg::PEAK_VOL_OFS, {5'h0, tg[1], pk[1]},
           "vol peak");
      // One flag cleared alone leaves the other standing.
      wr(peak_pkg::EVT_FLAGS_OFS, 32'h1 << peak_pkg::CWIN_BIT);
      rchk(peak_pkg::EVT_FLAGS_OFS, 32'h1 << peak_pkg::VWIN_BIT,
           "one clear");
    end
    wr(peak_pkg::EVT_FLAGS_OFS, 32'h0180_0000);
    tick(1);
    chk({31'h0, interrupt_out_n}, 32'h1, "done clear");
    pk_exp = pk;
    tag_exp = tg;
    prev_ok = chk_on;
  endtask

  // ******************************************************************
  // Main sequence.
  // ******************************************************************
  initial begin
    logic [2:0] sels [3];
    logic [31:0] keep;
    int i;
    int k;
    int len;
    sels = '{3'b001, 3'b011, 3'b111};
    rst_b = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = '0;
    reg_wdata = '0;
    smp_valid = 1'b0;
    cur_smp = '0;
    vol_smp = '0;
    zx_pulse = '0;
    k = $urandom(82);
    tick(2);
    rst_b = 1'b1;
    tick(3);
    chk({31'h0, interrupt_out_n}, 32'h1, "irq idle");
    rchk(peak_pkg::CUR_LIM_OFS, {8'h0, peak_pkg::LIM_RST},
         "ilim");
    rchk(peak_pkg::VOL_LIM_OFS, {8'h0, peak_pkg::LIM_RST},
         "vlim");
    rchk(peak_pkg::MODE_OFS, {24'h0, peak_pkg::MODE_RST}, "mode rst");
    rchk(peak_pkg::WIN_LEN_OFS, {24'h0, peak_pkg::WIN_RST}, "len rst");
    rchk(peak_pkg::EVT_EN_OFS, 32'h0, "enables rst");
    rchk(peak_pkg::EVT_FLAGS_OFS, 32'h0, "flags rst");
    rchk(16'h0123, 32'h0, "unmapped");
    rd(peak_pkg::PEAK_CUR_OFS);
    keep = d;
    wr(peak_pkg::PEAK_CUR_OFS, 32'hffff_ffff);
    rchk(peak_pkg::PEAK_CUR_OFS, keep, "read only");
    $display("test reset done");
    excess(0);
    excess(1);
    for (i = 0; i < 3; i++) begin
      len = $urandom_range(5, 2);
      wr(peak_pkg::EVT_EN_OFS, (i == 2) ? 32'h0100_0000 : 32'h0080_0000);
      wr(peak_pkg::MODE_OFS, {27'h0, sels[i], 2'b00});
      rchk(peak_pkg::MODE_OFS, {27'h0, sels[i], 2'b00}, "mode");
      wr(peak_pkg::WIN_LEN_OFS, 32'(len));
      run_win(sels[i], len, 1'b0);
      // Partial count, then a length write must restart it.
      for (k = 0; k < len - 1; k++) zx(sels[i] & ~(sels[i] << 1));
      wr(peak_pkg::WIN_LEN_OFS, 32'(len));
      prev_ok = 1'b0;
      run_win(sels[i], len, 1'b1);
      run_win(sels[i], len, 1'b1);
      $display("test window %0d done", i);
    end
    wrap_up();
  end

  // Prints the counts and the verdict, then ends the run.
  task automatic wrap_up;
    $display("Checks %0d, mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
endmodule // testbench
`default_nettype wire
